/* hw/ccd_pkg.sv */
// constants and types shared by the channel change decoder files
// assumes a byte stream of request elements framed by the modem mac
package ccd_pkg;
    // element types carried in the request
    localparam logic [7:0] CCD_T_US_ID = 8'h01;
    localparam logic [7:0] CCD_T_DS_PARAM = 8'h02;
    localparam logic [7:0] CCD_T_INIT_TECH = 8'h03;
    localparam logic [7:0] CCD_T_UCD_SUB = 8'h04;
    // downstream frequency sub-element inside the downstream parameters
    localparam logic [7:0] CCD_ST_DS_FREQ = 8'h01;
    // re-initialization directive codes
    localparam logic [7:0] CCD_CODE_REINIT = 8'h00;
    localparam logic [7:0] CCD_CODE_INIT_MAINT = 8'h01;
    localparam logic [7:0] CCD_CODE_STN_MAINT = 8'h02;
    localparam logic [7:0] CCD_CODE_EITHER = 8'h03;
    localparam logic [7:0] CCD_CODE_DIRECT = 8'h04;
    // fragment length for all but the last descriptor fragment
    localparam logic [7:0] CCD_FRAG_LEN = 8'hfe;
    // descriptor cache geometry and service identifier width
    localparam int CCD_CACHE_AW = 10;
    localparam int CCD_CACHE_DW = 8;
    localparam int CCD_SID_W = 14;
    // reset values and the full descriptor length
    localparam logic [7:0] CCD_BYTE_RST = 8'h00;
    localparam logic [31:0] CCD_FREQ_RST = 32'h0000_0000;
    localparam logic [13:0] CCD_SID_RST = 14'h0000;
    localparam logic [10:0] CCD_LEN_RST = 11'h000;
    localparam logic [10:0] CCD_LEN_FULL = 11'h400;

    // what the modem does once on the new channels
    typedef enum logic [1:0] {
        CCD_ACT_FULL,
        CCD_ACT_INIT_MAINT,
        CCD_ACT_STN_MAINT,
        CCD_ACT_DIRECT
    } ccd_act_e;
endpackage

/* hw/ccd_cache_mem.sv */
// byte cache holding the reassembled substitute channel descriptor
// assumes one writer and one reader on the same clock
`timescale 1ns/1ns
`default_nettype none
module ccd_cache_mem
    import ccd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic wr_en,
    input wire logic [CCD_CACHE_AW-1:0] wr_addr,
    input wire logic [CCD_CACHE_DW-1:0] wr_data,
    input wire logic [CCD_CACHE_AW-1:0] rd_addr,
    output logic [CCD_CACHE_DW-1:0] rd_data
);
    logic [CCD_CACHE_DW-1:0] mem [0:(1<<CCD_CACHE_AW)-1];

    // plain ram, no reset so it maps to block memory
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered read, one cycle of latency
    always_ff @(posedge clk_sys) begin
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

/* hw/ccd_decoder.sv */
// channel change request decoder: parses request elements, selects the
// new channels, then issues the re-initialization action once synced.
// assumes element bytes arrive after the fixed message header, with
// in_last on the final byte; channel tuning is done outside.
// Operation
// - directive element type 3 carries one code byte: 0 full reinit, 1 initial, 2 station, 3 either, 4 direct, 5 to 255 reserved.
// - the new channels are selected first and the directive is acted on only afterwards.
// - code 0 starts on the new channel with the initialization service identifier.
// - codes 1 to 4 keep the primary service identifier for ranging unless a substitute is supplied.
// - code 0 launches the complete initialization sequence once downstream lock is reached.
// - code 0 uses only the upstream identifier and downstream parameter elements.
// - code 3 lets the modem range in whichever maintenance region it picks.
// - code 4 resumes normal operation once synchronized, with no ranging.
// - a request without a directive element is handled as code 0.
// - a substitute descriptor is cached and applied only after synchronizing.
// - descriptor fragments are appended in arrival order, byte after byte.
`timescale 1ns/1ns
`default_nettype none
module ccd_decoder
    import ccd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    input wire logic in_last,
    output logic in_ready,
    output logic chsel_req,
    input wire logic chan_synced,
    output logic [7:0] new_us_id,
    output logic new_us_valid,
    output logic [31:0] new_ds_freq,
    output logic new_ds_valid,
    input wire logic [CCD_SID_W-1:0] primary_sid,
    input wire logic [CCD_SID_W-1:0] init_sid,
    input wire logic sid_sub_valid,
    input wire logic [CCD_SID_W-1:0] sid_sub,
    input wire logic prefer_station,
    output logic act_valid,
    output ccd_act_e act_kind,
    output logic use_init_sid,
    output logic [CCD_SID_W-1:0] ranging_sid,
    output logic ucd_apply,
    output logic [10:0] ucd_len,
    output logic ucd_frag_err,
    input wire logic [CCD_CACHE_AW-1:0] ucd_rd_addr,
    output logic [CCD_CACHE_DW-1:0] ucd_rd_data
);
    typedef enum logic [1:0] {PS_TYPE, PS_LEN, PS_VAL} ccd_ps_e;
    typedef enum logic [1:0] {SB_TYPE, SB_LEN, SB_VAL} ccd_sb_e;
    typedef enum logic {SQ_IDLE, SQ_SWITCH} ccd_sq_e;

    ccd_ps_e ps_r;
    ccd_sb_e sb_r;
    ccd_sq_e sq_r;
    logic [7:0] type_r, rem_r, sub_type_r, sub_rem_r, code_r, last_frag_r;
    logic code_seen_r, ucd_seen_r, msg_open_r, frag_open_r;
    logic accept, first, in_val, wr_en, msg_end;
    ccd_act_e kind_nxt;

    assign in_ready = (sq_r == SQ_IDLE);
    assign chsel_req = (sq_r == SQ_SWITCH);
    assign accept = in_valid && in_ready;
    assign first = accept && !msg_open_r;
    assign in_val = accept && (ps_r == PS_VAL);
    assign msg_end = accept && in_last;
    // overflowing bytes are dropped rather than wrapping over the head
    assign wr_en = in_val && (type_r == CCD_T_UCD_SUB) && (ucd_len != CCD_LEN_FULL);

    // element framing: type, length, value bytes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ps_r <= PS_TYPE;
            type_r <= CCD_BYTE_RST;
            rem_r <= CCD_BYTE_RST;
            msg_open_r <= 1'b0;
        end else if (accept) begin
            msg_open_r <= !in_last;
            case (ps_r)
                PS_TYPE: begin
                    type_r <= in_data;
                    ps_r <= in_last ? PS_TYPE : PS_LEN;
                end
                PS_LEN: begin
                    rem_r <= in_data;
                    ps_r <= (in_last || in_data == CCD_BYTE_RST) ? PS_TYPE : PS_VAL;
                end
                PS_VAL: begin
                    rem_r <= rem_r - 8'h01;
                    ps_r <= (in_last || rem_r == 8'h01) ? PS_TYPE : PS_VAL;
                end
                default: ps_r <= PS_TYPE;
            endcase
        end
    end

    // sub-element walk inside the downstream parameters element
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sb_r <= SB_TYPE;
            sub_type_r <= CCD_BYTE_RST;
            sub_rem_r <= CCD_BYTE_RST;
        end else if (accept && ps_r != PS_VAL) begin
            sb_r <= SB_TYPE;
        end else if (in_val && type_r == CCD_T_DS_PARAM) begin
            case (sb_r)
                SB_TYPE: begin
                    sub_type_r <= in_data;
                    sb_r <= SB_LEN;
                end
                SB_LEN: begin
                    sub_rem_r <= in_data;
                    sb_r <= (in_data == CCD_BYTE_RST) ? SB_TYPE : SB_VAL;
                end
                SB_VAL: begin
                    sub_rem_r <= sub_rem_r - 8'h01;
                    sb_r <= (sub_rem_r == 8'h01) ? SB_TYPE : SB_VAL;
                end
                default: sb_r <= SB_TYPE;
            endcase
        end
    end

    // channel selection fields; only the valid flags are cleared at the start of each request
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            new_us_id <= CCD_BYTE_RST;
            new_us_valid <= 1'b0;
            new_ds_freq <= CCD_FREQ_RST;
            new_ds_valid <= 1'b0;
        end else if (first) begin
            new_us_valid <= 1'b0;
            new_ds_valid <= 1'b0;
        end else if (in_val && type_r == CCD_T_US_ID) begin
            new_us_id <= in_data;
            new_us_valid <= 1'b1;
        end else if (in_val && type_r == CCD_T_DS_PARAM && sb_r == SB_VAL
                     && sub_type_r == CCD_ST_DS_FREQ) begin
            // frequency arrives most significant byte first
            new_ds_freq <= {new_ds_freq[23:0], in_data};
            new_ds_valid <= 1'b1;
        end
    end

    // directive code capture, last occurrence wins
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            code_r <= CCD_CODE_REINIT;
            code_seen_r <= 1'b0;
        end else if (first) begin
            code_seen_r <= 1'b0;
        end else if (in_val && type_r == CCD_T_INIT_TECH) begin
            code_r <= in_data;
            code_seen_r <= 1'b1;
        end
    end

    // descriptor reassembly: each value byte lands at the running length
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ucd_len <= CCD_LEN_RST;
            ucd_seen_r <= 1'b0;
        end else if (first) begin
            ucd_len <= CCD_LEN_RST;
            ucd_seen_r <= 1'b0;
        end else if (wr_en) begin
            ucd_len <= ucd_len + 11'h001;
            ucd_seen_r <= 1'b1;
        end
    end

    // head-end fragment sizing check, a short fragment followed by another
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            last_frag_r <= CCD_BYTE_RST;
            frag_open_r <= 1'b0;
            ucd_frag_err <= 1'b0;
        end else if (first) begin
            frag_open_r <= 1'b0;
            ucd_frag_err <= 1'b0;
        end else if (accept && ps_r == PS_LEN && type_r == CCD_T_UCD_SUB) begin
            if (frag_open_r && last_frag_r != CCD_FRAG_LEN) begin
                ucd_frag_err <= 1'b1;
            end
            last_frag_r <= in_data;
            frag_open_r <= 1'b1;
        end
    end

    ccd_cache_mem u_cache (
        .clk_sys(clk_sys),
        .wr_en(wr_en),
        .wr_addr(ucd_len[CCD_CACHE_AW-1:0]),
        .wr_data(in_data),
        .rd_addr(ucd_rd_addr),
        .rd_data(ucd_rd_data)
    );

    // directive decode; reserved codes fall back to full reinit
    always_comb begin
        kind_nxt = CCD_ACT_FULL;
        if (code_seen_r) begin
            case (code_r)
                CCD_CODE_INIT_MAINT: kind_nxt = CCD_ACT_INIT_MAINT;
                CCD_CODE_STN_MAINT: kind_nxt = CCD_ACT_STN_MAINT;
                // region is the modem's pick, steered by prefer_station
                CCD_CODE_EITHER: kind_nxt = prefer_station ? CCD_ACT_STN_MAINT
                                                           : CCD_ACT_INIT_MAINT;
                CCD_CODE_DIRECT: kind_nxt = CCD_ACT_DIRECT;
                default: kind_nxt = CCD_ACT_FULL;
            endcase
        end
    end

    // sequencer: select channels, wait for sync, then act
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sq_r <= SQ_IDLE;
        end else begin
            case (sq_r)
                SQ_IDLE: sq_r <= msg_end ? SQ_SWITCH : SQ_IDLE;
                SQ_SWITCH: sq_r <= chan_synced ? SQ_IDLE : SQ_SWITCH;
                default: sq_r <= SQ_IDLE;
            endcase
        end
    end

    // action outputs, registered one cycle after sync is seen
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            act_valid <= 1'b0;
            act_kind <= CCD_ACT_FULL;
            use_init_sid <= 1'b0;
            ranging_sid <= CCD_SID_RST;
            ucd_apply <= 1'b0;
        end else begin
            act_valid <= (sq_r == SQ_SWITCH) && chan_synced;
            ucd_apply <= 1'b0;
            if (sq_r == SQ_SWITCH && chan_synced) begin
                // full kind tells the init engine to run the whole sequence
                act_kind <= kind_nxt;
                if (kind_nxt == CCD_ACT_FULL) begin
                    use_init_sid <= 1'b1;
                    ranging_sid <= init_sid;
                end else begin
                    use_init_sid <= 1'b0;
                    ranging_sid <= sid_sub_valid ? sid_sub : primary_sid;
                    // cached descriptor ignored on full reinit
                    ucd_apply <= ucd_seen_r;
                end
            end
        end
    end

    sequence s_msg_end;
        accept && in_last;
    endsequence
    sequence s_synced;
        (sq_r == SQ_SWITCH) && chan_synced;
    endsequence

    chk_select_first: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_msg_end |=> chsel_req && !act_valid)
        else $error("channel select did not precede action");
    chk_act_cause: assert property (@(posedge clk_sys) disable iff (!arst_n)
        act_valid |-> $past(chsel_req) && $past(chan_synced))
        else $error("action without prior sync");
    chk_full_sid: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_synced and (kind_nxt == CCD_ACT_FULL)) |=> use_init_sid && ranging_sid == $past(init_sid))
        else $error("full reinit not using init sid");
    chk_maint_sid: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_synced and (kind_nxt != CCD_ACT_FULL && !sid_sub_valid))
        |=> !use_init_sid && ranging_sid == $past(primary_sid))
        else $error("ranging sid not primary");
    chk_no_code_full: assert property (@(posedge clk_sys) disable iff (!arst_n)
        act_valid && !code_seen_r |-> act_kind == CCD_ACT_FULL)
        else $error("missing directive not full reinit");
    chk_full_no_ucd: assert property (@(posedge clk_sys) disable iff (!arst_n)
        act_valid && act_kind == CCD_ACT_FULL |-> !ucd_apply)
        else $error("descriptor applied on full reinit");
    chk_direct_code: assert property (@(posedge clk_sys) disable iff (!arst_n)
        act_valid && code_seen_r && code_r == CCD_CODE_DIRECT |-> act_kind == CCD_ACT_DIRECT)
        else $error("direct code not decoded");
    chk_either_code: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_synced and (code_seen_r && code_r == CCD_CODE_EITHER))
        |=> act_kind == ($past(prefer_station) ? CCD_ACT_STN_MAINT : CCD_ACT_INIT_MAINT))
        else $error("either code region wrong");
    chk_ucd_after_sync: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ucd_apply |-> act_valid && $past(chan_synced))
        else $error("descriptor applied before sync");
    chk_cache_append: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_en && !first |=> ucd_len == $past(ucd_len) + 11'h001)
        else $error("descriptor length not appended");
endmodule
`default_nettype wire

/* tb/ccd_headend_model.sv */
// head-end model: sends channel change requests as a stream of element bytes
// assumes the decoder takes a byte at a rising edge while in_ready is high
`timescale 1ns/1ns
`default_nettype none
module ccd_headend_model
    import ccd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic in_ready,
    output logic in_valid,
    output logic [7:0] in_data,
    output logic in_last
);
    int stall_err;

    // idle lines at time zero
    initial begin
        in_valid = 1'b0;
        in_data = 8'h5a;
        in_last = 1'b0;
        stall_err = 0;
    end

    // body holds no message header; caller keeps its change count current
    task automatic add_desc(ref logic [7:0] q[$], input logic [7:0] body[$]);
        int n;
        while (body.size() > 0) begin
            n = (body.size() > int'(CCD_FRAG_LEN)) ? int'(CCD_FRAG_LEN) : body.size();
            q.push_back(CCD_T_UCD_SUB);
            q.push_back(8'(n));
            repeat (n) q.push_back(body.pop_front());
        end
    endtask

    // called at a falling edge; each byte stands until a rising edge takes it
    task automatic send_req(input logic [7:0] q[$], input int gap);
        int w;
        foreach (q[i]) begin
            if (i > 0 && gap > 0) begin
                in_valid = 1'b0;
                in_data = ~in_data; // released line never shows the stale byte
                repeat (gap) @(negedge clk_sys);
            end
            in_valid = 1'b1;
            in_data = q[i];
            in_last = (i == q.size() - 1);
            w = 0;
            // in_ready only moves on rising edges, so a falling-edge look is safe
            while (!in_ready && w < 1000) begin
                @(negedge clk_sys);
                w++;
            end
            if (w >= 1000) stall_err++;
            @(posedge clk_sys);
            @(negedge clk_sys);
        end
        in_valid = 1'b0;
        in_last = 1'b0;
        in_data = ~in_data;
    endtask
endmodule
`default_nettype wire

/* tb/ccd_decoder_bench.sv */
// self-checking bench for the channel change decoder
// assumes the head-end model drives the byte stream, the bench the rest
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR %0t: got %0h expected %0h", $time, got, exp); end end
module ccd_decoder_bench
    import ccd_pkg::*;
;
    logic clk_sys, arst_n, in_valid, in_last, in_ready, chsel_req, chan_synced;
    logic new_us_valid, new_ds_valid, sid_sub_valid, prefer_station, act_valid;
    logic use_init_sid, ucd_apply, ucd_frag_err;
    logic [7:0] in_data, new_us_id;
    logic [31:0] new_ds_freq;
    logic [CCD_SID_W-1:0] primary_sid, init_sid, sid_sub, ranging_sid;
    ccd_act_e act_kind;
    logic [10:0] ucd_len;
    logic [CCD_CACHE_AW-1:0] ucd_rd_addr;
    logic [CCD_CACHE_DW-1:0] ucd_rd_data;
    int num_errors = 0;
    int cmp_count = 0;

    ccd_decoder dut (.clk_sys(clk_sys), .arst_n(arst_n), .in_valid(in_valid),
        .in_data(in_data), .in_last(in_last), .in_ready(in_ready), .chsel_req(chsel_req),
        .chan_synced(chan_synced), .new_us_id(new_us_id), .new_us_valid(new_us_valid),
        .new_ds_freq(new_ds_freq), .new_ds_valid(new_ds_valid), .primary_sid(primary_sid),
        .init_sid(init_sid), .sid_sub_valid(sid_sub_valid), .sid_sub(sid_sub),
        .prefer_station(prefer_station), .act_valid(act_valid), .act_kind(act_kind),
        .use_init_sid(use_init_sid), .ranging_sid(ranging_sid), .ucd_apply(ucd_apply),
        .ucd_len(ucd_len), .ucd_frag_err(ucd_frag_err), .ucd_rd_addr(ucd_rd_addr),
        .ucd_rd_data(ucd_rd_data));

    ccd_headend_model hem (.clk_sys(clk_sys), .in_ready(in_ready), .in_valid(in_valid),
        .in_data(in_data), .in_last(in_last));

    // 50 MHz
    always #10 clk_sys = ~clk_sys;

    // what the decoder should do once synced, per directive code
    function automatic ccd_act_e exp_kind(input int code, input logic pref);
        case (code)
            1: return CCD_ACT_INIT_MAINT;
            2: return CCD_ACT_STN_MAINT;
            3: return pref ? CCD_ACT_STN_MAINT : CCD_ACT_INIT_MAINT;
            4: return CCD_ACT_DIRECT;
            default: return CCD_ACT_FULL; // code 0, missing or reserved code
        endcase
    endfunction

    // upstream id, downstream parameters, then a directive unless code is -1
    // a one-byte non-frequency sub-element leads, so it must not leak into the frequency
    task automatic build(output logic [7:0] q[$], input logic [7:0] us,
            input logic [31:0] fr, input int code);
        q = {CCD_T_US_ID, 8'h01, us, CCD_T_DS_PARAM, 8'h09, 8'h02, 8'h01, 8'h01,
            CCD_ST_DS_FREQ, 8'h04, fr[31:24], fr[23:16], fr[15:8], fr[7:0]};
        if (code >= 0) q = {q, CCD_T_INIT_TECH, 8'h01, 8'(code)};
    endtask

    // send, hold sync off a while, then sync and judge the action pulse
    task automatic run_req(input logic [7:0] q[$], input int code, input logic cached,
            input logic [7:0] us, input logic [31:0] fr);
        ccd_act_e k;
        logic [CCD_SID_W-1:0] rsid;
        int w;
        k = exp_kind(code, prefer_station);
        rsid = sid_sub_valid ? sid_sub : primary_sid;
        if (k == CCD_ACT_FULL) rsid = init_sid;
        hem.send_req(q, code & 1); // odd codes pace the bytes slowly
        w = 0;
        while (chsel_req !== 1'b1 && w < 50) begin
            @(negedge clk_sys);
            w++;
        end
        `CHK(chsel_req, 1'b1);
        `CHK(new_us_id, us);
        `CHK(new_ds_freq, fr);
        `CHK(new_us_valid, 1'b1);
        `CHK(new_ds_valid, 1'b1);
        repeat (3) begin
            `CHK(act_valid, 1'b0);
            `CHK(in_ready, 1'b0);
            @(negedge clk_sys);
        end
        chan_synced = 1'b1;
        @(negedge clk_sys);
        chan_synced = 1'b0;
        `CHK(act_valid, 1'b1);
        `CHK(act_kind, k);
        `CHK(use_init_sid, k == CCD_ACT_FULL);
        `CHK(ranging_sid, rsid);
        `CHK(ucd_apply, cached && k != CCD_ACT_FULL);
        @(negedge clk_sys);
        `CHK(act_valid, 1'b0);
        `CHK(ucd_apply, 1'b0);
    endtask

    // every defined code, plus reserved 5 and 255; a new upstream id each time
    task automatic test_codes();
        logic [7:0] q[$];
        int codes[9] = '{0, 1, 2, 3, 3, 4, 5, 255, 4};
        logic [7:0] us;
        logic [31:0] fr;
        foreach (codes[i]) begin
            prefer_station = (i == 4);
            sid_sub_valid = (i == 8);
            us = 8'(i + 16);
            fr = 32'h2000_0000 + 32'(i) * 32'h0000_f424;
            build(q, us, fr, codes[i]);
            if (i == 0 || i == 5) hem.add_desc(q, '{8'h07, 8'h21, 8'h33});
            run_req(q, codes[i], i == 0 || i == 5, us, fr);
        end
    endtask

    // no directive element at all
    task automatic test_no_directive();
        logic [7:0] q[$];
        build(q, 8'h2a, 32'h1111_7a12, -1);
        run_req(q, -1, 1'b0, 8'h2a, 32'h1111_7a12);
    endtask

    // long descriptor in a full and a short fragment, read back across the seam
    task automatic test_fragments();
        logic [7:0] q[$];
        logic [7:0] body[$];
        int addr[4] = '{0, 253, 254, 256};
        for (int i = 0; i < 257; i++) body.push_back(8'(i * 7 + 3));
        build(q, 8'h31, 32'h0800_0000, -1);
        hem.add_desc(q, body);
        q = {q, CCD_T_INIT_TECH, 8'h01, CCD_CODE_STN_MAINT};
        run_req(q, 2, 1'b1, 8'h31, 32'h0800_0000);
        `CHK(ucd_len, 11'h101);
        `CHK(ucd_frag_err, 1'b0);
        foreach (addr[j]) begin
            ucd_rd_addr = 10'(addr[j]);
            @(negedge clk_sys);
            `CHK(ucd_rd_data, body[addr[j]]);
        end
    endtask

    // short fragment followed by another: flagged, still concatenated
    task automatic test_frag_error();
        logic [7:0] q[$];
        build(q, 8'h32, 32'h0900_0000, -1);
        q = {q, CCD_T_UCD_SUB, 8'h03, 8'ha1, 8'ha2, 8'ha3, CCD_T_UCD_SUB, 8'h02, 8'hb1, 8'hb2,
            CCD_T_INIT_TECH, 8'h01, CCD_CODE_DIRECT};
        run_req(q, 4, 1'b1, 8'h32, 32'h0900_0000);
        `CHK(ucd_len, 11'h005);
        `CHK(ucd_frag_err, 1'b1);
        ucd_rd_addr = 10'h003;
        @(negedge clk_sys);
        `CHK(ucd_rd_data, 8'hb1);
    endtask

    task automatic finish_test();
        $display("comparisons %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // main sequence: two cycles of reset, then the scenarios
    initial begin
        clk_sys = 1'b0;
        arst_n = 1'b0;
        chan_synced = 1'b0;
        sid_sub_valid = 1'b0;
        prefer_station = 1'b0;
        primary_sid = 14'h0123;
        init_sid = 14'h0002;
        sid_sub = 14'h0345;
        ucd_rd_addr = 10'h000;
        repeat (2) @(negedge clk_sys);
        `CHK(in_ready, 1'b1);
        `CHK(chsel_req, 1'b0);
        `CHK(act_valid, 1'b0);
        `CHK(ucd_len, CCD_LEN_RST);
        arst_n = 1'b1;
        @(negedge clk_sys);
        test_codes();
        test_no_directive();
        test_fragments();
        test_frag_error();
        `CHK(hem.stall_err, 0);
        finish_test();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk_sys);
        num_errors++;
        $display("ERROR %0t: timeout", $time);
        finish_test();
    end
endmodule
`default_nettype wire
